// >>> bench/adc_status_rate_and_filter_select_registers_bench.sv
// adc_status_rate_and_filter_select_registers_bench: self-checking bench for the register bank.
// assumes asmr_regs and asmr_host_model; inputs change at the falling edge.
`default_nettype none
module adc_status_rate_and_filter_select_registers_bench
    import asmr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // signals
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        cmdValid, rspValid, convRestart, writeLocked, rateLegal, filterLegal;
    logic [7:0]  cmdByte, cmdData, rspData, convModeCtrl;
    logic [3:0]  evt = 4'h0;  // crc, start, new data, data read
    logic [3:0]  pins = 4'h0; // ref low, amp high, amp low, clock
    logic [3:0]  sampleRateCode;
    logic [2:0]  filterCode, sincOrder, alm;
    logic [16:0] rateDeciSps;
    int          nMismatch = 0;
    int          samplesChecked = 0;
    logic [16:0] rateTab [0:12] = '{17'd25, 17'd50, 17'd100, 17'd166, 17'd200, 17'd500,
        17'd600, 17'd1000, 17'd4000, 17'd12000, 17'd24000, 17'd48000, 17'd72000};
    always #2 sys_clk = ~sys_clk;
    asmr_host_model asmr_host_model_inst (.sys_clk(sys_clk), .cmdValid(cmdValid),
        .cmdByte(cmdByte), .cmdData(cmdData));
    asmr_regs asmr_regs_inst (.sys_clk(sys_clk), .rst_n(rst_n), .cmdValid(cmdValid),
        .cmdByte(cmdByte), .cmdData(cmdData), .rspValid(rspValid), .rspData(rspData),
        .crcErrEvt(evt[0]), .convStart(evt[1]), .newDataEvt(evt[2]), .dataReadEvt(evt[3]),
        .ampLowPin(pins[2]), .ampHighPin(pins[1]), .refLowPin(pins[0]), .clkExtPin(pins[3]),
        .sampleRateCode(sampleRateCode), .filterCode(filterCode), .convModeCtrl(convModeCtrl),
        .rateLegal(rateLegal), .filterLegal(filterLegal), .rateDeciSps(rateDeciSps),
        .sincOrder(sincOrder), .convRestart(convRestart), .writeLocked(writeLocked));
    // ==========================================================
    // checking
    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            nMismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // a response with no note pending can never match 1ffff
    always @(negedge sys_clk) begin
        if (rspValid === 1'b1) begin
            if (asmr_host_model_inst.expQ.size() == 0) chk({9'h0, rspData}, 17'h1ffff);
            else chk({9'h0, rspData}, {9'h0, asmr_host_model_inst.expQ.pop_front()});
        end
    end
    task automatic endOfTest();
        $display("mismatches %0d comparisons %0d", nMismatch, samplesChecked);
        if (nMismatch == 0 && samplesChecked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : endOfTest
    // ==========================================================
    // host helpers
    task automatic drain();
        for (int i = 0; i < 8 && asmr_host_model_inst.expQ.size() != 0; i++) begin
            @(posedge sys_clk);
        end
        if (asmr_host_model_inst.expQ.size() != 0) begin
            nMismatch++;
            endOfTest();
        end
    endtask : drain
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        asmr_host_model_inst.rd(a, e);
        asmr_host_model_inst.idle(1);
        drain();
    endtask : rd
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        asmr_host_model_inst.wr(a, d);
        asmr_host_model_inst.idle(1);
    endtask : wr
    task automatic op(input logic [7:0] b);
        asmr_host_model_inst.send(b, 8'($urandom));
        asmr_host_model_inst.idle(1);
    endtask : op
    task automatic pulse(input int k);
        @(negedge sys_clk) evt[k] = 1'b1;
        @(negedge sys_clk) evt[k] = 1'b0;
    endtask : pulse
    task automatic wrMode(input logic [7:0] d);
        int r;
        int f;
        r = d[6:3];
        f = d[2:0];
        wr(5'h02, d);
        chk(convRestart, 1'b1);
        chk({sampleRateCode, filterCode}, {d[6:3], d[2:0]});
        asmr_host_model_inst.idle(1);
        chk(convRestart, 1'b0);
        chk(rateLegal, r < 13);
        chk(rateDeciSps, (r < 13) ? rateTab[r] : 17'h0);
        chk(filterLegal, f < 5);
        chk(sincOrder, (f < 4) ? 3'(f + 1) : 3'h0);
        rd(5'h02, d);
    endtask : wrMode
    // ==========================================================
    // scenarios
    initial begin
        void'($urandom(32'ha7494e4f));
        repeat (20) @(negedge sys_clk);
        rst_n = 1'b1;
        for (int k = 0; k < 2; k++) begin
            // back-to-back reads of every place, one unmapped
            asmr_host_model_inst.rd(5'h01, 8'h01);
            asmr_host_model_inst.rd(5'h02, 8'h24);
            asmr_host_model_inst.rd(5'h03, 8'h01);
            rd(5'h1f, 8'h00);
            chk(writeLocked, 1'b0);
            if (k == 1) begin
                endOfTest();
            end
            wr(5'h01, 8'hbe);
            rd(5'h01, 8'h00);
            pulse(0);
            rd(5'h01, 8'h40);
            wr(5'h01, 8'h41);
            rd(5'h01, 8'h40);
            wr(5'h01, 8'h00);
            rd(5'h01, 8'h00);
            pulse(2);
            rd(5'h01, 8'h04);
            pulse(3);
            rd(5'h01, 8'h00);
            // alarms latch after the pin falls, until a conversion starts
            for (int j = 0; j < 6; j++) begin
                // first pass raises all three together so the joint check is reached
                alm = (j == 0) ? 3'h7 : 3'($urandom);
                @(negedge sys_clk) pins[2:0] = alm;
                repeat (4) @(negedge sys_clk);
                pins[2:0] = 3'h0;
                repeat (4) @(negedge sys_clk);
                rd(5'h01, {2'h0, alm, 3'h0});
                pulse(1);
                rd(5'h01, 8'h00);
            end
            @(negedge sys_clk) pins[3] = 1'b1;
            repeat (4) @(negedge sys_clk);
            rd(5'h01, 8'h02);
            // every legal rate and filter code; the host never sends reserved ones
            for (int i = 0; i < 13; i++) begin
                wrMode({1'b0, 4'(i), 3'(i % 5)});
            end
            wrMode(8'h24);
            wr(5'h03, 8'h5a);
            chk({convRestart, convModeCtrl}, 9'h15a);
            op(8'hf2);
            chk(writeLocked, 1'b1);
            rd(5'h01, 8'h82);
            wr(5'h02, 8'h0a);
            chk(convRestart, 1'b0);
            rd(5'h02, 8'h24);
            op(8'hf5);
            rd(5'h01, 8'h02);
            wrMode(8'h19);
            op(8'hf2);
            pulse(0);
            // a second reset clears protect and error and sets the reset flag
            @(negedge sys_clk) pins[3] = 1'b0;
            rst_n = 1'b0;
            repeat (20) @(negedge sys_clk);
            rst_n = 1'b1;
        end
    end
endmodule : adc_status_rate_and_filter_select_registers_bench
`default_nettype wire

// >>> bench/asmr_host_model.sv
// asmr_host_model: host controller issuing register commands to the bank.
// assumes the bench calls its tasks; command lines change at the falling edge.
`default_nettype none
module asmr_host_model
    import asmr_pkg::*;
(
    // clock
    input  wire logic       sys_clk,
    // command port
    output logic            cmdValid,
    output logic [7:0]      cmdByte,
    output logic [7:0]      cmdData
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // expected read answers, oldest first
    logic [7:0] expQ[$];
    initial begin
        cmdValid = 1'b0;
        cmdByte  = 8'h00;
        cmdData  = 8'h5a;
    end
    // ==========================================================
    // command driving; valid stays high across back-to-back calls
    task automatic send(input logic [7:0] b, input logic [7:0] d);
        @(negedge sys_clk);
        cmdValid = 1'b1;
        cmdByte  = b;
        cmdData  = d;
    endtask : send
    // idle lines toggle so a stale byte is never mistaken for a command
    task automatic idle(input int n);
        repeat (n) begin
            @(negedge sys_clk);
            cmdValid = 1'b0;
            cmdByte  = ~cmdByte;
            cmdData  = ~cmdData;
        end
    endtask : idle
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        expQ.push_back(e);
        send({OPC_READ_HI, a}, 8'($urandom));
    endtask : rd
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        send({OPC_WRITE_HI, a}, d);
    endtask : wr
endmodule : asmr_host_model
`default_nettype wire

// >>> hw/asmr_mode_decode.sv
// asmr_mode_decode: turns the rate and filter codes into usable settings.
// assumes codes come straight from the register; outputs are combinational.
`default_nettype none
module asmr_mode_decode
    import asmr_pkg::*;
(
    // codes
    input  wire logic [3:0]  rateCode,
    input  wire logic [2:0]  filterCode,
    // decoded
    output logic             rateLegal,
    output logic             filterLegal,
    output logic [16:0]      rateDeciSps,
    output logic [2:0]       sincOrder
);
    // =========================================================
    // decode
    always_comb begin
        rateLegal   = (rateCode <= RATE_MAX_CODE);
        filterLegal = (filterCode <= FILT_MAX_CODE);
        // reserved rate codes fall back to zero rather than alias a real rate
        rateDeciSps = rateLegal ? RATE_DECI_SPS[rateCode] : 17'h00000;
        // fir and reserved report order zero; sinc1..4 report 1..4
        sincOrder   = (filterCode < FILT_FIR) ? filterCode + 3'h1 : 3'h0;
    end
endmodule : asmr_mode_decode
`default_nettype wire

// >>> hw/asmr_regs.sv
// asmr_regs: device status register and rate/filter select register bank.
// assumes command and event inputs on sys_clk; alarm and clock-detect inputs are pins.
// Behaviour
// - status bit 7 reads 1 after the protect command and 0 after the release command, 0 at reset.
// - a check error sets status bit 6, which stays set until the host writes it to 0.
// - status bit 5 shows the amplifier-below-limit alarm and 0 otherwise.
// - status bit 4 shows the amplifier-above-limit alarm and 0 otherwise.
// - status bit 3 shows the reference-below-limit alarm and 0 otherwise.
// - all three alarm flags clear by themselves at each conversion start unless that alarm is still present.
// - status bit 2 is 1 while conversion data are unread and 0 once read.
// - status bit 1 reports the automatically chosen clock, 1 for external, 0 for internal.
// - status bit 0 is set by every reset and the host may write it to 0 to spot the next one.
// - the status register sits at address 0x01 and resets to 0x01.
// - bits 6:3 of the mode register select the data rate, codes 1101 to 1111 reserved.
// - bits 2:0 of the mode register select the filter, codes 101 to 111 reserved.
// - the mode register sits at address 0x02 and resets to 0x24.
// - while protected all register writes are ignored but reads still work.
// - one register per command, read with 0x20 plus address and write with 0x40 plus address.
// - writing the mode register restarts the conversion in progress.
`default_nettype none
module asmr_regs
    import asmr_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // command port from the command engine
    input  wire logic        cmdValid,
    input  wire logic [7:0]  cmdByte,
    input  wire logic [7:0]  cmdData,
    output logic             rspValid,
    output logic [7:0]       rspData,
    // conversion events from the converter core
    input  wire logic        crcErrEvt,
    input  wire logic        convStart,
    input  wire logic        newDataEvt,
    input  wire logic        dataReadEvt,
    // analog monitor pins
    input  wire logic        ampLowPin,
    input  wire logic        ampHighPin,
    input  wire logic        refLowPin,
    input  wire logic        clkExtPin,
    // settings to the converter core
    output logic [3:0]       sampleRateCode,
    output logic [2:0]       filterCode,
    output logic [7:0]       convModeCtrl,
    output logic             rateLegal,
    output logic             filterLegal,
    output logic [16:0]      rateDeciSps,
    output logic [2:0]       sincOrder,
    output logic             convRestart,
    output logic             writeLocked
);
    // =========================================================
    // state
    typedef struct packed {
        logic [SY_W-1:0] syncA;
        logic [SY_W-1:0] syncB;
        logic            locked;
        logic            check_error_flag;
        logic            ampLow;
        logic            ampHigh;
        logic            refLow;
        logic            newData;
        logic            clkExt;
        logic            resetSeen;
        logic [7:0]      rateSel;
        logic [7:0]      convCtrl;
        logic            rspValid;
        logic [7:0]      rspData;
        logic            restart;
        logic            rateLegal;
        logic            filterLegal;
        logic [16:0]     rateDeciSps;
        logic [2:0]      sincOrder;
    } asmr_state_s;

    asmr_state_s state_q;
    asmr_state_s state_d;

    // =========================================================
    // helpers
    function automatic logic [7:0] asmr_status_byte(input asmr_state_s s);
        logic [7:0] b;
        b              = 8'h00;
        b[ST_LOCK]     = s.locked;
        b[ST_CHKERR]   = s.check_error_flag;
        b[ST_AMPLOW]   = s.ampLow;
        b[ST_AMPHIGH]  = s.ampHigh;
        b[ST_REFLOW]   = s.refLow;
        b[ST_NEWDATA]  = s.newData;
        b[ST_CLKEXT]   = s.clkExt;
        b[ST_RESET]    = s.resetSeen;
        return b;
    endfunction : asmr_status_byte

    // =========================================================
    // command decode
    logic       isRead;
    logic       isWrite;
    logic       isLock;
    logic       isUnlock;
    logic [4:0] cmdAddr;
    logic       wrAccept;
    logic       wrStatus;
    logic       wrRateSel;
    logic       wrConvCtrl;

    always_comb begin
        cmdAddr  = cmdByte[4:0];
        isRead   = cmdValid && (cmdByte[7:5] == OPC_READ_HI);
        isWrite  = cmdValid && (cmdByte[7:5] == OPC_WRITE_HI);
        isLock   = cmdValid && (cmdByte == OPC_LOCK);
        isUnlock = cmdValid && (cmdByte == OPC_UNLOCK);
        // protect state gates every write, reads are untouched
        wrAccept = isWrite && !state_q.locked;
        wrStatus = wrAccept && (cmdAddr == ADDR_STATUS);
        wrRateSel  = wrAccept && (cmdAddr == ADDR_RATE_SEL);
        wrConvCtrl = wrAccept && (cmdAddr == ADDR_CONV_CTRL);
    end

    // =========================================================
    // mode decode
    logic        decRateLegal;
    logic        decFilterLegal;
    logic [16:0] decRateDeciSps;
    logic [2:0]  decSincOrder;

    asmr_mode_decode u_decode (
        .rateCode    (state_q.rateSel[M0_RATE_LSB +: M0_RATE_W]),
        .filterCode  (state_q.rateSel[M0_FILT_LSB +: M0_FILT_W]),
        .rateLegal   (decRateLegal),
        .filterLegal (decFilterLegal),
        .rateDeciSps (decRateDeciSps),
        .sincOrder   (decSincOrder)
    );

    // =========================================================
    // next state
    always_comb begin
        state_d = state_q;
        // pins pass two flops; only the second stage is read
        state_d.syncA = {clkExtPin, refLowPin, ampHighPin, ampLowPin};
        state_d.syncB = state_q.syncA;

        // protect and release commands always act, even while protected
        if (isLock) begin
            state_d.locked = 1'b1;
        end else if (isUnlock) begin
            state_d.locked = 1'b0;
        end

        // sticky check error; a new error beats a clearing write
        state_d.check_error_flag = crcErrEvt
                       || (state_q.check_error_flag && !(wrStatus && !cmdData[ST_CHKERR]));

        // alarms follow the monitor and drop at conversion start; a live alarm wins
        state_d.ampLow  = state_q.syncB[SY_AMPLOW]
                        || (state_q.ampLow && !convStart);
        state_d.ampHigh = state_q.syncB[SY_AMPHIGH]
                        || (state_q.ampHigh && !convStart);
        state_d.refLow  = state_q.syncB[SY_REFLOW]
                        || (state_q.refLow && !convStart);

        // new data beats a read that lands in the same cycle
        state_d.newData = newDataEvt || (state_q.newData && !dataReadEvt);

        state_d.clkExt  = state_q.syncB[SY_CLKEXT];

        // host may only clear the reset marker; only a reset sets it
        if (wrStatus && !cmdData[ST_RESET]) begin
            state_d.resetSeen = 1'b0;
        end

        if (wrRateSel) begin
            state_d.rateSel = cmdData;
        end
        if (wrConvCtrl) begin
            state_d.convCtrl = cmdData;
        end
        // either mode register write throws away the conversion under way
        state_d.restart = wrRateSel || wrConvCtrl;

        // one byte answered per read command, unmapped reads as zero
        state_d.rspValid = isRead;
        if (isRead) begin
            unique case (cmdAddr)
                ADDR_STATUS: state_d.rspData = asmr_status_byte(state_q);
                ADDR_RATE_SEL:  state_d.rspData = state_q.rateSel;
                ADDR_CONV_CTRL: state_d.rspData = state_q.convCtrl;
                default:     state_d.rspData = UNMAPPED_RD;
            endcase
        end

        state_d.rateLegal   = decRateLegal;
        state_d.filterLegal = decFilterLegal;
        state_d.rateDeciSps = decRateDeciSps;
        state_d.sincOrder   = decSincOrder;
    end

    // =========================================================
    // registers
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_q             <= '0;
            state_q.resetSeen   <= STATUS_RESET[ST_RESET];
            state_q.rateSel     <= RATE_SEL_RESET;
            state_q.convCtrl    <= CONV_CTRL_RESET;
            state_q.rateLegal   <= 1'b1;
            state_q.filterLegal <= 1'b1;
        end else begin
            state_q <= state_d;
        end
    end

    // =========================================================
    // outputs
    always_comb begin
        rspValid       = state_q.rspValid;
        rspData        = state_q.rspData;
        sampleRateCode = state_q.rateSel[M0_RATE_LSB +: M0_RATE_W];
        filterCode     = state_q.rateSel[M0_FILT_LSB +: M0_FILT_W];
        convModeCtrl   = state_q.convCtrl;
        rateLegal      = state_q.rateLegal;
        filterLegal    = state_q.filterLegal;
        rateDeciSps    = state_q.rateDeciSps;
        sincOrder      = state_q.sincOrder;
        convRestart    = state_q.restart;
        writeLocked    = state_q.locked;
    end

    // =========================================================
    // checks
    lock_cmd_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        isLock |=> writeLocked && state_q.locked)
        else $error("protect command did not set lock bit");

    unlock_cmd_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        isUnlock |=> !writeLocked)
        else $error("release command did not clear lock bit");

    crc_sticky_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (crcErrEvt || (state_q.check_error_flag && !wrStatus)) |=> state_q.check_error_flag)
        else $error("check error flag lost");

    crc_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (wrStatus && !cmdData[ST_CHKERR] && !crcErrEvt) |=> !state_q.check_error_flag)
        else $error("check error flag not cleared by write");

    alarm_follow_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ampLowPin && ampHighPin && refLowPin ##1 ampLowPin && ampHighPin && refLowPin
        |=> ##1 state_q.ampLow && state_q.ampHigh && state_q.refLow)
        else $error("alarm pins not reflected after two syncs");

    alarm_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (convStart && state_q.syncB[SY_W-2:0] == 3'h0)
        |=> !state_q.ampLow && !state_q.ampHigh && !state_q.refLow)
        else $error("alarms survived conversion start");

    new_data_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (newDataEvt || (state_q.newData && !dataReadEvt)) |=> state_q.newData)
        else $error("new data flag dropped without a read");

    data_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (dataReadEvt && !newDataEvt) |=> !state_q.newData)
        else $error("new data flag not cleared by read");

    clock_src_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clkExtPin [*3] |=> state_q.clkExt)
        else $error("clock source bit does not follow detector");

    clock_int_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (!clkExtPin) [*3] |=> !state_q.clkExt)
        else $error("clock source bit stuck at external");

    reset_vals_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(rst_n) |-> asmr_status_byte(state_q) == STATUS_RESET
                         && state_q.rateSel == RATE_SEL_RESET
                         && state_q.convCtrl == CONV_CTRL_RESET)
        else $error("wrong reset values");

    locked_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (isWrite && writeLocked) |=> $stable(state_q.rateSel) && $stable(state_q.convCtrl)
                                     && !convRestart)
        else $error("write accepted while protected");

    read_rsp_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (isRead && cmdAddr == ADDR_RATE_SEL) |=> rspValid && rspData == $past(state_q.rateSel))
        else $error("read answer wrong");

    status_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (isRead && cmdAddr == ADDR_STATUS)
        |=> rspValid && rspData[ST_LOCK] == $past(writeLocked)
            && rspData[ST_RESET] == $past(state_q.resetSeen))
        else $error("status read answer wrong");

    restart_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wrRateSel |=> convRestart && state_q.rateSel == $past(cmdData))
        else $error("mode write did not restart conversion");

    restart_pulse_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !(wrRateSel || wrConvCtrl) |=> !convRestart)
        else $error("restart pulse without a mode write");

    reset_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !state_q.resetSeen |=> !state_q.resetSeen)
        else $error("reset flag set without a reset");
endmodule : asmr_regs
`default_nettype wire

// >>> include/asmr_pkg.sv
// asmr_pkg: constants shared by the status and rate/filter register bank.
// assumes a command engine on sys_clk that hands over one decoded command byte at a time.
`default_nettype none
package asmr_pkg;
    // =========================================================
    // command opcodes (upper three bits select the class)
    localparam logic [2:0] OPC_READ_HI  = 3'h1;
    localparam logic [2:0] OPC_WRITE_HI = 3'h2;
    localparam logic [7:0] OPC_LOCK     = 8'hf2;
    localparam logic [7:0] OPC_UNLOCK   = 8'hf5;

    // =========================================================
    // register addresses
    localparam logic [4:0] ADDR_STATUS    = 5'h01;
    localparam logic [4:0] ADDR_RATE_SEL  = 5'h02;
    localparam logic [4:0] ADDR_CONV_CTRL = 5'h03;

    // =========================================================
    // reset values
    localparam logic [7:0] STATUS_RESET    = 8'h01;
    localparam logic [7:0] RATE_SEL_RESET  = 8'h24;
    localparam logic [7:0] CONV_CTRL_RESET = 8'h01;
    localparam logic [7:0] UNMAPPED_RD     = 8'h00;

    // =========================================================
    // status field positions
    localparam int ST_LOCK    = 7;
    localparam int ST_CHKERR  = 6;
    localparam int ST_AMPLOW  = 5;
    localparam int ST_AMPHIGH = 4;
    localparam int ST_REFLOW  = 3;
    localparam int ST_NEWDATA = 2;
    localparam int ST_CLKEXT  = 1;
    localparam int ST_RESET   = 0;

    // =========================================================
    // rate and filter select field layout
    localparam int M0_RATE_LSB = 3;
    localparam int M0_RATE_W   = 4;
    localparam int M0_FILT_LSB = 0;
    localparam int M0_FILT_W   = 3;
    localparam logic [3:0] RATE_MAX_CODE = 4'hc;
    localparam logic [2:0] FILT_MAX_CODE = 3'h4;
    localparam logic [2:0] FILT_FIR      = 3'h4;

    // sample rates in tenths of a sample per second; 16.6 is truncated to 166
    localparam logic [0:12][16:0] RATE_DECI_SPS = '{
        17'h00019, 17'h00032, 17'h00064, 17'h000a6, 17'h000c8, 17'h001f4, 17'h00258,
        17'h003e8, 17'h00fa0, 17'h02ee0, 17'h05dc0, 17'h0bb80, 17'h11940};

    // =========================================================
    // synchroniser lanes for pin inputs
    localparam int SY_AMPLOW  = 0;
    localparam int SY_AMPHIGH = 1;
    localparam int SY_REFLOW  = 2;
    localparam int SY_CLKEXT  = 3;
    localparam int SY_W       = 4;
endpackage : asmr_pkg
`default_nettype wire
